// File: src/slc_pkg.sv
package slc_pkg;
  localparam logic [11:0] OFF_SLEEP_CTRL = 12'h000;
  localparam logic [11:0] OFF_VMON_CTRL  = 12'h004;
  localparam logic [11:0] OFF_STATUS     = 12'h008;
  localparam int ARM_BIT        = 0;
  localparam int MODE_LSB       = 1;
  localparam int MODE_W         = 3;
  localparam int KEEP_BIT       = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CORE_BIT  = 2;
  localparam int STAT_PIN_BIT   = 3;
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_SNR  = 3'h1;
  localparam logic [2:0] MODE_PD   = 3'h2;
  localparam logic [2:0] MODE_RST  = 3'h0;
  localparam int CLK_PERIOD_NS     = 20;
  localparam int RST_MIN_PULSE_US  = 2;
  localparam int RST_MIN_CYC       = (RST_MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int PIN_CNT_W         = 7;
  localparam logic [PIN_CNT_W-1:0] RST_MIN_CNT = PIN_CNT_W'(RST_MIN_CYC);
  localparam int WAKE_HOLD_CYC     = 4;
  localparam int TOUT_W            = 20;
  localparam logic [TOUT_W-1:0] WAKE_HOLD_CNT = TOUT_W'(WAKE_HOLD_CYC - 1);
  localparam int IN_PIN  = 3;
  localparam int IN_POR  = 2;
  localparam int IN_BOD  = 1;
  localparam int IN_TEMP = 0;
  localparam logic [3:0] SYNC_INIT = 4'hc;
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_STARTUP = 2'b10,
    ST_HOLD    = 2'b11
  } slc_state_e;
endpackage

// File: src/slc_sleep_reset_ctrl.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - sleep entered only by sleep instruction while arm bit is one
// - mode select: 000 idle, 001 noise reduction, 010 power-down, rest reserved
// - after interrupt wake cpu held four cycles beyond start-up, then resumes
// - any reset while sleeping leaves sleep through reset vector
// - sleep control resets to zero, upper 28 bits read zero
// - idle stops only cpu and flash clocks, any interrupt wakes
// - noise reduction stops cpu, flash, io clocks; fast rc feeds timers
// - noise reduction timer2/3 events wake only if masked in and global enable
// - power-down stops fast rc, external clock, monitors unless keep bit set
// - power-down woken only by resets, lf start, level, pin change interrupts, and monitor events with keep bit set
// - power-down halts every clock except enabled slow rc
// - power-down wake delayed by fuse selected start-up period
// - monitor events wake power-down only with keep bit set
// - reset returns registers to initial values, fetch from reset vector
// - reset output asserts asynchronously for pin and power-on; watchdog, brown-out, temperature assert it a clock after internal reset
// - internal reset extended by fuse selected delay after sources release
// - five reset sources; watchdog, brown-out, temperature only when enabled
// - reset pin low at least 2 us resets the device
// - power-on detector reasserts reset immediately, delay counter on rise
// - reset pin high starts delay counter, release after time-out
// - one-cycle watchdog pulse, its falling edge starts delay counter
module slc_sleep_reset_ctrl #(
  parameter logic [slc_pkg::TOUT_W-1:0] T_SUT0 = 20'h00010,
  parameter logic [slc_pkg::TOUT_W-1:0] T_SUT1 = 20'h00400,
  parameter logic [slc_pkg::TOUT_W-1:0] T_SUT2 = 20'h04000,
  parameter logic [slc_pkg::TOUT_W-1:0] T_SUT3 = 20'h10000,
  parameter logic [slc_pkg::TOUT_W-1:0] T_CKX  = 20'h00040
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleepInstr,
  input  wire logic        anyIrq,
  input  wire logic        extLevelIrq,
  input  wire logic        pinChangeIrq,
  input  wire logic        lfStartIrq,
  input  wire logic        monitorIrq,
  input  wire logic [1:0]  timerEvt,
  input  wire logic [1:0]  timerIrqMask,
  input  wire logic        globalIrqEn,
  input  wire logic        slowRcEnable,
  input  wire logic        resetPin_n,
  input  wire logic        powerOk,
  input  wire logic        brownoutLow,
  input  wire logic        overTemp,
  input  wire logic        wdtTimeout,
  input  wire logic        wdtEnable,
  input  wire logic        bodEnable,
  input  wire logic        tempEnable,
  input  wire logic [1:0]  startupTimeFuses,
  input  wire logic [3:0]  clockSelectFuses,
  output logic             cpuClkEn,
  output logic             flashClkEn,
  output logic             ioClkEn,
  output logic             timerClkEn,
  output logic             fastRcEn,
  output logic             extClkEn,
  output logic             monitorEn,
  output logic             slowRcEn,
  output logic             sleeping,
  output logic             cpuResume,
  output logic             mcuReset
);
  typedef struct packed {
    slc_pkg::slc_state_e               state;
    logic [2:0]                        mode;
    logic                              arm;
    logic                              keep;
    logic [2:0]                        effMode;
    logic [slc_pkg::TOUT_W-1:0]        wCnt;
    logic [3:0]                        s0;
    logic [3:0]                        s1;
    logic [3:0]                        s2;
    logic [3:0]                        lvl;
    logic [slc_pkg::PIN_CNT_W-1:0]     pinCnt;
    logic                              pinRst;
    logic [slc_pkg::TOUT_W-1:0]        tCnt;
    logic                              coreRst;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    logic                              cpuClkEn;
    logic                              flashClkEn;
    logic                              ioClkEn;
    logic                              timerClkEn;
    logic                              fastRcEn;
    logic                              extClkEn;
    logic                              monitorEn;
    logic                              slowRcEn;
    logic                              sleeping;
    logic                              cpuResume;
  } slc_st_s;

  slc_st_s st_r;
  slc_st_s st_nxt;
  logic    srcActive;
  logic    wakeNow;
  logic    asyncRst_n;
  logic    ioHold_r;

  function automatic logic [slc_pkg::TOUT_W-1:0] toutOf(input logic [1:0] sut,
                                                       input logic       ck);
    logic [slc_pkg::TOUT_W-1:0] base;
    unique case (sut)
      2'h0: base = T_SUT0;
      2'h1: base = T_SUT1;
      2'h2: base = T_SUT2;
      2'h3: base = T_SUT3;
    endcase
    return ck ? base + T_CKX : base;
  endfunction

  // pin and power-on levels go straight into the asynchronous path, no clock needed
  assign asyncRst_n = rst_n & resetPin_n & powerOk;

  always_comb begin
    logic [31:0] rd;
    logic        setup;
    logic        acc;
    logic        hitSc;
    logic        hitVm;
    logic        hitSt;
    logic        sl;
    logic        su;
    logic        pd;
    logic        snr;
    rd     = '0;
    {setup, acc, hitSc, hitVm, hitSt, sl, su, pd, snr} = '0;
    st_nxt = st_r;
    st_nxt.cpuResume = 1'b0;
    st_nxt.s0  = {resetPin_n, powerOk, brownoutLow, overTemp};
    st_nxt.s1  = st_r.s0;
    st_nxt.s2  = st_r.s1;
    st_nxt.lvl = (~(st_r.s1 ^ st_r.s2) & st_r.s2) | ((st_r.s1 ^ st_r.s2) & st_r.lvl);
    // short pin glitches only reach the asynchronous path
    if (st_r.lvl[slc_pkg::IN_PIN]) begin
      st_nxt.pinCnt = '0;
      st_nxt.pinRst = 1'b0;
    end else if (st_r.pinCnt != slc_pkg::RST_MIN_CNT) begin
      st_nxt.pinCnt = st_r.pinCnt + 7'h01;
    end else begin
      st_nxt.pinRst = 1'b1;
    end
    srcActive = !st_r.lvl[slc_pkg::IN_POR] | st_r.pinRst
              | (wdtEnable & wdtTimeout)
              | (bodEnable & st_r.lvl[slc_pkg::IN_BOD])
              | (tempEnable & st_r.lvl[slc_pkg::IN_TEMP]);
    if (srcActive) begin
      st_nxt.coreRst = 1'b1;
      st_nxt.tCnt    = toutOf(startupTimeFuses, clockSelectFuses[0]);
    end else if (st_r.tCnt != '0) begin
      st_nxt.tCnt = st_r.tCnt - 20'h00001;
    end else begin
      st_nxt.coreRst = 1'b0;
    end
    setup = psel & !penable;
    acc   = psel & penable & st_r.pready;
    hitSc = paddr[11:2] == slc_pkg::OFF_SLEEP_CTRL[11:2];
    hitVm = paddr[11:2] == slc_pkg::OFF_VMON_CTRL[11:2];
    hitSt = paddr[11:2] == slc_pkg::OFF_STATUS[11:2];
    if (hitSc) begin
      rd[slc_pkg::MODE_LSB +: slc_pkg::MODE_W] = st_r.mode;
      rd[slc_pkg::ARM_BIT] = st_r.arm;
    end else if (hitVm) begin
      rd[slc_pkg::KEEP_BIT] = st_r.keep;
    end else if (hitSt) begin
      rd[slc_pkg::STAT_STATE_LSB +: 2] = st_r.state;
      rd[slc_pkg::STAT_CORE_BIT] = st_r.coreRst;
      rd[slc_pkg::STAT_PIN_BIT]  = st_r.pinRst;
    end
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & !(hitSc | hitVm | hitSt);
    st_nxt.prdata  = (setup && !pwrite) ? rd : '0;
    if (acc && pwrite && hitSc) begin
      st_nxt.mode = pwdata[slc_pkg::MODE_LSB +: slc_pkg::MODE_W];
      st_nxt.arm  = pwdata[slc_pkg::ARM_BIT];
    end
    if (acc && pwrite && hitVm) begin
      st_nxt.keep = pwdata[slc_pkg::KEEP_BIT];
    end
    unique case (st_r.effMode)
      slc_pkg::MODE_SNR: wakeNow = (|(timerEvt & timerIrqMask) & globalIrqEn)
                                 | extLevelIrq | pinChangeIrq | lfStartIrq | monitorIrq;
      slc_pkg::MODE_PD:  wakeNow = extLevelIrq | pinChangeIrq | lfStartIrq
                                 | (st_r.keep & monitorIrq);
      default:           wakeNow = anyIrq;
    endcase
    unique case (st_r.state)
      slc_pkg::ST_ACTIVE: begin
        if (sleepInstr && st_r.arm) begin
          st_nxt.state = slc_pkg::ST_SLEEP;
          if (st_r.mode == slc_pkg::MODE_SNR || st_r.mode == slc_pkg::MODE_PD) begin
            st_nxt.effMode = st_r.mode;
          end else begin
            st_nxt.effMode = slc_pkg::MODE_IDLE;
          end
        end
      end
      slc_pkg::ST_SLEEP: begin
        if (wakeNow && st_r.effMode == slc_pkg::MODE_PD) begin
          st_nxt.state = slc_pkg::ST_STARTUP;
          st_nxt.wCnt  = toutOf(startupTimeFuses, clockSelectFuses[0]);
        end else if (wakeNow) begin
          st_nxt.state = slc_pkg::ST_HOLD;
          st_nxt.wCnt  = slc_pkg::WAKE_HOLD_CNT;
        end
      end
      slc_pkg::ST_STARTUP: begin
        if (st_r.wCnt == '0) begin
          st_nxt.state = slc_pkg::ST_HOLD;
          st_nxt.wCnt  = slc_pkg::WAKE_HOLD_CNT;
        end else begin
          st_nxt.wCnt = st_r.wCnt - 20'h00001;
        end
      end
      slc_pkg::ST_HOLD: begin
        if (st_r.wCnt == '0) begin
          st_nxt.state     = slc_pkg::ST_ACTIVE;
          st_nxt.cpuResume = 1'b1;
        end else begin
          st_nxt.wCnt = st_r.wCnt - 20'h00001;
        end
      end
    endcase
    // reset wins over any pending wake or register write
    if (st_r.coreRst) begin
      st_nxt.state     = slc_pkg::ST_ACTIVE;
      st_nxt.mode      = slc_pkg::MODE_RST;
      st_nxt.arm       = 1'b0;
      st_nxt.keep      = 1'b0;
      st_nxt.cpuResume = 1'b0;
    end
    sl  = st_nxt.state == slc_pkg::ST_SLEEP;
    su  = st_nxt.state == slc_pkg::ST_STARTUP;
    pd  = sl && st_nxt.effMode == slc_pkg::MODE_PD;
    snr = sl && st_nxt.effMode == slc_pkg::MODE_SNR;
    st_nxt.cpuClkEn   = st_nxt.state == slc_pkg::ST_ACTIVE;
    st_nxt.flashClkEn = !(sl | su);
    st_nxt.ioClkEn    = !(pd | snr | su);
    st_nxt.timerClkEn = !(pd | su);
    st_nxt.fastRcEn   = !pd;
    st_nxt.extClkEn   = !pd;
    st_nxt.monitorEn  = !pd | st_nxt.keep;
    st_nxt.slowRcEn   = slowRcEnable;
    st_nxt.sleeping   = sl | su;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.s0      <= slc_pkg::SYNC_INIT;
      st_r.s1      <= slc_pkg::SYNC_INIT;
      st_r.s2      <= slc_pkg::SYNC_INIT;
      st_r.lvl     <= slc_pkg::SYNC_INIT;
      st_r.coreRst <= 1'b1;
      st_r.tCnt    <= T_SUT0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge asyncRst_n) begin
    if (!asyncRst_n) begin
      ioHold_r <= 1'b1;
    end else begin
      ioHold_r <= st_r.coreRst;
    end
  end

  assign prdata     = st_r.prdata;
  assign pready     = st_r.pready;
  assign pslverr    = st_r.pslverr;
  assign cpuClkEn   = st_r.cpuClkEn;
  assign flashClkEn = st_r.flashClkEn;
  assign ioClkEn    = st_r.ioClkEn;
  assign timerClkEn = st_r.timerClkEn;
  assign fastRcEn   = st_r.fastRcEn;
  assign extClkEn   = st_r.extClkEn;
  assign monitorEn  = st_r.monitorEn;
  assign slowRcEn   = st_r.slowRcEn;
  assign sleeping   = st_r.sleeping;
  assign cpuResume  = st_r.cpuResume;
  assign mcuReset   = ioHold_r;

  property p_no_sleep_unarmed;
    @(posedge ref_clk) disable iff (!rst_n)
    (st_r.state == slc_pkg::ST_ACTIVE && sleepInstr && !st_r.arm) |=> !sleeping;
  endproperty
  a_no_sleep_unarmed: assert property (p_no_sleep_unarmed) else $error("unarmed sleep");

  property p_idle_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_IDLE)
      |-> !cpuClkEn && !flashClkEn && ioClkEn && timerClkEn && fastRcEn;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock gating wrong");

  property p_snr_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_SNR)
      |-> !cpuClkEn && !flashClkEn && !ioClkEn && timerClkEn && fastRcEn;
  endproperty
  a_snr_clocks: assert property (p_snr_clocks) else $error("noise mode gating wrong");

  property p_pd_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_PD)
      |-> !fastRcEn && !extClkEn && !timerClkEn && !ioClkEn && monitorEn == st_r.keep;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("power-down gating wrong");

  property p_wake_hold;
    @(posedge ref_clk) disable iff (!rst_n || st_r.coreRst || srcActive)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode != slc_pkg::MODE_PD && wakeNow)
      |=> (!cpuClkEn)[*4] ##1 (cpuResume && cpuClkEn);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake hold not four cycles");

  property p_snr_timer_wake;
    @(posedge ref_clk) disable iff (!rst_n || st_r.coreRst)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_SNR
      && |(timerEvt & timerIrqMask) && globalIrqEn) |=> st_r.state == slc_pkg::ST_HOLD;
  endproperty
  a_snr_timer_wake: assert property (p_snr_timer_wake) else $error("timer wake missed");

  property p_pd_no_wake;
    @(posedge ref_clk) disable iff (!rst_n || st_r.coreRst)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_PD
      && !extLevelIrq && !pinChangeIrq && !lfStartIrq && !(st_r.keep && monitorIrq))
      |=> st_r.state == slc_pkg::ST_SLEEP;
  endproperty
  a_pd_no_wake: assert property (p_pd_no_wake) else $error("power-down woke wrongly");

  property p_pd_startup;
    @(posedge ref_clk) disable iff (!rst_n || st_r.coreRst)
    (st_r.state == slc_pkg::ST_SLEEP && st_r.effMode == slc_pkg::MODE_PD && wakeNow)
      |=> st_r.state == slc_pkg::ST_STARTUP && !cpuClkEn && fastRcEn;
  endproperty
  a_pd_startup: assert property (p_pd_startup) else $error("no start-up delay");

  property p_reset_exits_sleep;
    @(posedge ref_clk) disable iff (!rst_n)
    st_r.coreRst |=> st_r.state == slc_pkg::ST_ACTIVE && !st_r.arm && st_r.mode == '0;
  endproperty
  a_reset_exits_sleep: assert property (p_reset_exits_sleep) else $error("reset left sleep");

  property p_release_after_tout;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(st_r.coreRst) |-> $past(st_r.tCnt) == '0 && !$past(srcActive);
  endproperty
  a_release_after_tout: assert property (p_release_after_tout) else $error("early release");

  property p_source_holds_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    srcActive |=> st_r.coreRst ##1 mcuReset;
  endproperty
  a_source_holds_reset: assert property (p_source_holds_reset) else $error("reset not held");

  property p_pin_filter;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st_r.pinRst) |-> $past(st_r.pinCnt) == slc_pkg::RST_MIN_CNT;
  endproperty
  a_pin_filter: assert property (p_pin_filter) else $error("pin reset too early");
endmodule // slc_sleep_reset_ctrl

// File: tb/slc_host_model.sv
`timescale 1ns/1ps
module slc_host_model (
  input  wire logic       ref_clk,
  input  wire logic       cpuResume,
  output logic            sleepInstr,
  output logic            anyIrq,
  output logic            extLevelIrq,
  output logic            pinChangeIrq,
  output logic            lfStartIrq,
  output logic            monitorIrq,
  output logic [1:0]      timerEvt,
  output logic            resetPin_n,
  output logic            wdtTimeout
);
  initial begin
    {sleepInstr, anyIrq, extLevelIrq, pinChangeIrq, lfStartIrq, monitorIrq} = 6'h00;
    timerEvt = 2'h0;
    resetPin_n = 1'b1;
    wdtTimeout = 1'b0;
  end
  // caller arms just before this, except in the unarmed check, and disarms after wake
  task automatic exec_sleep();
    @(posedge ref_clk) sleepInstr <= 1'b1;
    @(posedge ref_clk) sleepInstr <= 1'b0;
  endtask
  task automatic drive_src(input int s, input logic v);
    case (s)
      0: anyIrq <= v;
      1: extLevelIrq <= v;
      2: pinChangeIrq <= v;
      3: lfStartIrq <= v;
      4: monitorIrq <= v;
      default: timerEvt <= {v, v};
    endcase
  endtask
  // level held until the core resumes or holdMax cycles pass, a slow wake is never lost
  task automatic raise(input int s, input int holdMax, output int n);
    n = 0;
    @(posedge ref_clk) drive_src(s, 1'b1);
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (cpuResume !== 1'b1 && n < holdMax);
    @(posedge ref_clk) drive_src(s, 1'b0);
  endtask
  task automatic pin(input logic v);
    @(posedge ref_clk) resetPin_n <= v;
  endtask
  // watchdog expiry is a single clock pulse
  task automatic wdt_pulse();
    @(posedge ref_clk) wdtTimeout <= 1'b1;
    @(posedge ref_clk) wdtTimeout <= 1'b0;
  endtask
endmodule // slc_host_model

// File: tb/slc_sleep_reset_ctrl_tb.sv
`timescale 1ns/1ps
module slc_sleep_reset_ctrl_tb;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h00011c71;
  logic        pready, pslverr, sleepInstr, anyIrq, extLevelIrq, pinChangeIrq, lfStartIrq;
  logic        monitorIrq, resetPin_n, wdtTimeout, globalIrqEn = 1'b0, slowRcEnable = 1'b1;
  logic        powerOk = 1'b1, brownoutLow = 1'b0, overTemp = 1'b0, wdtEnable = 1'b0;
  logic        bodEnable = 1'b0, tempEnable = 1'b0, cpuClkEn, flashClkEn, ioClkEn, timerClkEn;
  logic        fastRcEn, extClkEn, monitorEn, slowRcEn, sleeping, cpuResume, mcuReset;
  logic [1:0]  timerEvt, timerIrqMask = 2'h0, startupTimeFuses = 2'h1;
  logic [3:0]  clockSelectFuses = 4'h1;
  logic [31:0] rd;
  logic        err;
  int          errors = 0, check_count = 0, n;

  always #10 ref_clk = ~ref_clk;

  slc_sleep_reset_ctrl #(.T_SUT0(20'h00008), .T_SUT1(20'h0000c), .T_SUT2(20'h0000e),
    .T_SUT3(20'h00010), .T_CKX(20'h00002)) u_slc_sleep_reset_ctrl (
    .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .sleepInstr, .anyIrq, .extLevelIrq, .pinChangeIrq, .lfStartIrq, .monitorIrq, .timerEvt,
    .timerIrqMask, .globalIrqEn, .slowRcEnable, .resetPin_n, .powerOk, .brownoutLow,
    .overTemp, .wdtTimeout, .wdtEnable, .bodEnable, .tempEnable, .startupTimeFuses,
    .clockSelectFuses, .cpuClkEn, .flashClkEn, .ioClkEn, .timerClkEn, .fastRcEn, .extClkEn,
    .monitorEn, .slowRcEn, .sleeping, .cpuResume, .mcuReset);

  slc_host_model u_slc_host_model (
    .ref_clk, .cpuResume, .sleepInstr, .anyIrq, .extLevelIrq, .pinChangeIrq, .lfStartIrq,
    .monitorIrq, .timerEvt, .resetPin_n, .wdtTimeout);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // gate pattern {cpu,flash,io,timer,fastRc,ext,monitor,slowRc}
  function automatic logic [7:0] exp_en(input logic [2:0] m, input logic k, input logic s);
    if (m == slc_pkg::MODE_PD) return {6'h00, k, s};
    if (m == slc_pkg::MODE_SNR) return {7'h0f, s};
    return {7'h1f, s};
  endfunction
  // start-up cycles for the current fuses, same small values as the instance overrides
  function automatic int tout_exp();
    int t;
    case (startupTimeFuses)
      2'h0: t = 8;
      2'h1: t = 12;
      2'h2: t = 14;
      default: t = 16;
    endcase
    return clockSelectFuses[0] ? t + 2 : t;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (k >= 50) begin
      errors++;
      $display("[FAIL] %0t bus answer timed out", $time);
      finish_test();
    end
  endtask
  task automatic wait_rst(input logic want, input int bound, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (mcuReset !== want && c < bound);
    if (c >= bound) begin
      errors++;
      $display("[FAIL] %0t reset level not reached", $time);
      finish_test();
    end
  endtask
  task automatic go_sleep(input logic [2:0] m, input logic k);
    seed = lfsr_next(seed);
    @(posedge ref_clk) {slowRcEnable, startupTimeFuses, clockSelectFuses} <= seed[6:0];
    apb(1'b1, slc_pkg::OFF_VMON_CTRL, {31'h0, k});
    apb(1'b0, slc_pkg::OFF_VMON_CTRL, 0);
    chk(rd, {31'h0, k}, "keep readback");
    apb(1'b1, slc_pkg::OFF_SLEEP_CTRL, {28'h0, m, 1'b1});
    u_slc_host_model.exec_sleep();
    @(posedge ref_clk);
    #1;
    chk(sleeping, 1, "sleep entry");
    chk({cpuClkEn, flashClkEn, ioClkEn, timerClkEn, fastRcEn, extClkEn, monitorEn, slowRcEn}
        , exp_en(m, k, slowRcEnable), "gates");
  endtask
  task automatic no_wake(input int s);
    u_slc_host_model.raise(s, 10, n);
    chk({cpuResume, sleeping}, 2'b01, "spurious wake");
  endtask
  task automatic wake(input int s, input int lo, input int hi);
    u_slc_host_model.raise(s, 300, n);
    chk(n >= lo && n <= hi, 1, "wake latency");
    apb(1'b1, slc_pkg::OFF_SLEEP_CTRL, 32'h0);
    chk({cpuClkEn, sleeping}, 2'b10, "resumed");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_rst(1'b0, 200, n);
    apb(1'b0, slc_pkg::OFF_SLEEP_CTRL, 0);
    chk(rd, 0, "reset value");
    apb(1'b0, 12'h00c, 0);
    chk({31'h0, err}, 1, "unmapped error");
    chk(rd, 0, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      apb(1'b1, slc_pkg::OFF_SLEEP_CTRL, seed & 32'hfffffffe);
      apb(1'b0, slc_pkg::OFF_SLEEP_CTRL, 0);
      chk(rd, seed & 32'h0000000e, "readback");
    end
    apb(1'b1, slc_pkg::OFF_SLEEP_CTRL, 32'h0);
    u_slc_host_model.exec_sleep();
    repeat (2) @(posedge ref_clk);
    #1;
    chk(sleeping, 0, "unarmed sleep");
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      go_sleep(3'(m), 1'b0);
      if (m == 1) begin
        @(posedge ref_clk) timerIrqMask <= 2'h3;
        no_wake(5);
        @(posedge ref_clk) {globalIrqEn, timerIrqMask} <= 3'b100;
        no_wake(5);
        @(posedge ref_clk) timerIrqMask <= 2'h3;
        wake(5, 5, 6);
        @(posedge ref_clk) {globalIrqEn, timerIrqMask} <= 3'b000;
      end else if (m == 2) begin
        no_wake(0);
        no_wake(4);
        wake(1, tout_exp() + 4, tout_exp() + 8);
      end else wake(0, 5, 6);
    end
    for (int s = 2; s < 5; s++) begin
      go_sleep(slc_pkg::MODE_PD, 1'b1);
      wake(s, tout_exp() + 4, tout_exp() + 8);
    end
    $display("test sleep modes done");
    go_sleep(slc_pkg::MODE_IDLE, 1'b0);
    @(posedge ref_clk) wdtEnable <= 1'b1;
    u_slc_host_model.wdt_pulse();
    wait_rst(1'b1, 10, n);
    chk(sleeping, 0, "reset leaves sleep");
    wait_rst(1'b0, 200, n);
    chk(n >= tout_exp(), 1, "wdt delay");
    apb(1'b0, slc_pkg::OFF_SLEEP_CTRL, 0);
    chk(rd, 0, "cleared by reset");
    @(posedge ref_clk) brownoutLow <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk(mcuReset, 0, "disabled brownout");
    @(posedge ref_clk) bodEnable <= 1'b1;
    wait_rst(1'b1, 10, n);
    @(posedge ref_clk) {brownoutLow, tempEnable, overTemp} <= 3'b011;
    wait_rst(1'b1, 40, n);
    @(posedge ref_clk) overTemp <= 1'b0;
    wait_rst(1'b0, 200, n);
    chk(n >= tout_exp(), 1, "source delay");
    @(posedge ref_clk) powerOk <= 1'b0;
    #1;
    chk(mcuReset, 1, "por async");
    repeat (5) @(posedge ref_clk);
    powerOk <= 1'b1;
    wait_rst(1'b0, 200, n);
    chk(n >= tout_exp(), 1, "por delay");
    u_slc_host_model.pin(1'b0);
    #1;
    chk(mcuReset, 1, "pin async");
    repeat (110) @(posedge ref_clk);
    apb(1'b0, slc_pkg::OFF_STATUS, 0);
    chk(rd, (32'h1 << slc_pkg::STAT_CORE_BIT) | (32'h1 << slc_pkg::STAT_PIN_BIT), "pin status");
    u_slc_host_model.pin(1'b1);
    wait_rst(1'b0, 200, n);
    chk(n >= tout_exp(), 1, "pin delay");
    $display("test resets done");
    finish_test();
  end
endmodule // slc_sleep_reset_ctrl_tb
